// file: src/sdram_pin_interface.sv
// Pin-level interface between the memory controller core and external synchronous memories.
//
// Operation
// - Memory clocks run at the system clock rate.
// - Each memory clock held low when disabled.
// - Write: set mask bit blocks its byte.
// - Read: masks gate memory output buffers per lane.
// - Mask bit n covers data bits 8n+7..8n.
// - Reset drives clocks, cke, selects, strobes, masks high.
// - Reset holds flash initialize/power-down output low.
// - Read data sampled on feedback clock edges.
`timescale 1ns/1ps

module sdram_pin_interface (
   input  wire logic                                 clk,
   input  wire logic                                 rstn,
   input  wire logic [sdram_pin_pkg::CLKS-1:0]       mem_clk_out_en,
   input  wire logic                                 req_valid,
   input  wire sdram_pin_pkg::mem_req_s              req,
   input  wire logic                                 flash_run,
   input  wire logic                                 mem_feedback_clk_in,
   input  wire logic [sdram_pin_pkg::DATA_W-1:0]     mem_dq_in,
   output logic      [sdram_pin_pkg::CLKS-1:0]       mem_clk_out,
   output logic                                      mem_cke,
   output logic      [sdram_pin_pkg::CHIPS-1:0]      mem_chip_sel_n,
   output logic                                      mem_row_strobe_n,
   output logic                                      mem_col_strobe_n,
   output logic                                      mem_write_en_n,
   output logic      [sdram_pin_pkg::LANES-1:0]      mem_data_mask,
   output logic                                      flash_init_powerdown_n,
   output logic      [sdram_pin_pkg::DATA_W-1:0]     rd_data,
   output logic                                      rd_valid
);
   import sdram_pin_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Turns a command into its strobe pattern; deselect keeps all high.
   function automatic mem_pins_s encode_cmd(input mem_cmd_e cmd, input logic [1:0] chip);
      mem_pins_s p;
      p = '{chip_sel_n: RST_CHIP_SEL, row_n: 1'b1, col_n: 1'b1, we_n: 1'b1};
      if (cmd != CMD_DESELECT) begin
         p.chip_sel_n       = ~(4'h1 << chip);
      end
      case (cmd)
         CMD_ACTIVATE:  {p.row_n, p.col_n, p.we_n} = STB_ACTIVATE;
         CMD_READ:      {p.row_n, p.col_n, p.we_n} = STB_READ;
         CMD_WRITE:     {p.row_n, p.col_n, p.we_n} = STB_WRITE;
         CMD_PRECHARGE: {p.row_n, p.col_n, p.we_n} = STB_PRECHARGE;
         CMD_REFRESH:   {p.row_n, p.col_n, p.we_n} = STB_REFRESH;
         CMD_LOAD_MODE: {p.row_n, p.col_n, p.we_n} = STB_LOAD_MODE;
         CMD_BURST_END: {p.row_n, p.col_n, p.we_n} = STB_BURST_END;
         default:       {p.row_n, p.col_n, p.we_n} = STB_NOP;
      endcase
      return p;
   endfunction

   // Clears every byte lane whose mask bit is set; lane n is bits 8n+7..8n.
   function automatic logic [DATA_W-1:0] lane_filter(input logic [DATA_W-1:0] d,
                                                     input logic [LANES-1:0]  m);
      logic [DATA_W-1:0] r;
      r = d;
      for (int i = 0; i < LANES; i++) begin
         if (m[i]) begin
            r[i*LANE_W +: LANE_W] = '0;
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic             in_reset;        // High from the cycle after reset is applied until the cycle after release.
   logic [CLKS-1:0]  clk_run;         // Registered per-clock enable.
   mem_pins_s        pins;            // Registered command pins.
   logic             cke_q;           // Registered clock enable.
   logic [LANES-1:0] dmask;           // Registered data masks.
   logic             flash_q;         // Registered flash control.
   logic [LANES-1:0] rd_mask;         // Mask of the latest read.
   logic             fb_s1;           // Feedback clock, first stage.
   logic             fb_s2;           // Feedback clock, second stage.
   logic             fb_s3;           // Feedback clock, edge history.
   logic [DATA_W-1:0] dq_d1;          // Read data, first stage.
   logic [DATA_W-1:0] dq_d2;          // Read data, aligned with fb_s2.

   // Decoded request; an idle cycle deselects every chip, so the pins keep their reset levels after release.
   wire              is_rw     = req_valid && (req.cmd == CMD_READ || req.cmd == CMD_WRITE);
   wire              is_read   = req_valid && (req.cmd == CMD_READ);
   wire mem_pins_s   next_pins = req_valid ? encode_cmd(req.cmd, req.chip) : encode_cmd(CMD_DESELECT, 2'h0);
   wire [LANES-1:0]  next_dmask = is_rw ? req.byte_mask : RST_DMASK;
   wire              fb_rise   = fb_s2 && !fb_s3;

   // ----------------------------------------------------------------
   // Memory clock outputs
   // ----------------------------------------------------------------

   // Tracks reset; the memory clocks keep their reset level for one cycle after release.
   always_ff @(posedge clk) begin
      in_reset <= !rstn;
   end

   // Samples the per-clock enable field.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clk_run <= RST_CLK_EN;
      end else begin
         clk_run <= mem_clk_out_en;
      end
   end

   // Forwards the system clock itself, so the rate is exactly equal.
   // A disabled clock parks low; reset parks both high.
   assign mem_clk_out = (!rstn || in_reset) ? RST_MEM_CLK : (clk_run & {CLKS{clk}});

   // ----------------------------------------------------------------
   // Command, clock enable and mask pins
   // ----------------------------------------------------------------

   // Registers the encoded command and the lane masks.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pins  <= '{chip_sel_n: RST_CHIP_SEL, row_n: RST_STROBES[2], col_n: RST_STROBES[1],
                    we_n: RST_STROBES[0]};
         cke_q <= RST_CKE;
         dmask <= RST_DMASK;
      end else begin
         pins  <= next_pins;
         cke_q <= req_valid ? req.cke : cke_q;
         dmask <= next_dmask;
      end
   end

   // Drives the flash initialize/power-down line; low holds the flash idle.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flash_q <= RST_FLASH_RUN;
      end else begin
         flash_q <= flash_run;
      end
   end

   assign mem_chip_sel_n         = pins.chip_sel_n;
   assign mem_row_strobe_n       = pins.row_n;
   assign mem_col_strobe_n       = pins.col_n;
   assign mem_write_en_n         = pins.we_n;
   assign mem_cke                = cke_q;
   assign mem_data_mask          = dmask;
   assign flash_init_powerdown_n = flash_q;

   // ----------------------------------------------------------------
   // Read capture on the returned feedback clock
   // ----------------------------------------------------------------

   // Synchronises the feedback clock and delays data by the same two stages.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fb_s1 <= 1'b0;
         fb_s2 <= 1'b0;
         fb_s3 <= 1'b0;
      end else begin
         fb_s1 <= mem_feedback_clk_in;
         fb_s2 <= fb_s1;
         fb_s3 <= fb_s2;
      end
   end

   // Data stages carry no reset; they are qualified by the edge pulse.
   always_ff @(posedge clk) begin
      dq_d1 <= mem_dq_in;
      dq_d2 <= dq_d1;
   end

   // Remembers the lane mask of the latest read.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_mask <= RST_DMASK;
      end else if (is_read) begin
         rd_mask <= req.byte_mask;
      end
   end

   // Captures a word on each rising feedback edge; masked lanes read zero.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_data  <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= fb_rise;
         if (fb_rise) begin
            rd_data <= lane_filter(dq_d2, rd_mask);
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   // Reset levels stand on every command and mask pin.
   AST_RESET_HIGH: assert property (@(posedge clk) !rstn |=>
      (mem_chip_sel_n == RST_CHIP_SEL && mem_row_strobe_n && mem_col_strobe_n && mem_write_en_n
       && mem_cke && mem_data_mask == RST_DMASK))
      else $error("Memory pins not high after reset.");

   // Flash stays in power-down through reset and the next cycle.
   AST_FLASH_LOW: assert property (@(posedge clk) !rstn |=> !flash_init_powerdown_n)
      else $error("Flash control not low in reset.");

   // Sampled in the high phase: an enabled clock shows high, a disabled one is parked low.
   AST_CLK_PARK: assert property (@(negedge clk) disable iff (!rstn)
      !in_reset |-> mem_clk_out == clk_run)
      else $error("Memory clock not gated by its enable.");

   // Clock run flags follow the enable field one cycle later.
   AST_CLK_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn) |-> clk_run == $past(mem_clk_out_en))
      else $error("Memory clock enable not applied.");

   // The issued command matches its strobe code.
   AST_CMD_CODE: assert property (@(posedge clk) disable iff (!rstn)
      req_valid |=> pins == encode_cmd($past(req.cmd), $past(req.chip)))
      else $error("Command strobes wrong.");

   // Without a request every chip select rests high, as it does straight after reset.
   AST_IDLE_DESELECT: assert property (@(posedge clk) disable iff (!rstn)
      !req_valid |=> mem_chip_sel_n == RST_CHIP_SEL)
      else $error("Chip select active while idle.");

   // A write presents its byte mask in the command cycle.
   AST_WRITE_MASK: assert property (@(posedge clk) disable iff (!rstn)
      (req_valid && req.cmd == CMD_WRITE) |=> (mem_data_mask == $past(req.byte_mask) && !mem_write_en_n))
      else $error("Write mask not driven.");

   // A read presents its output-buffer mask in the command cycle.
   AST_READ_MASK: assert property (@(posedge clk) disable iff (!rstn)
      is_read |=> (mem_data_mask == $past(req.byte_mask) && mem_write_en_n))
      else $error("Read mask not driven.");

   // A masked top lane always reads back zero.
   AST_LANE_MAP: assert property (@(posedge clk) disable iff (!rstn)
      (fb_rise && rd_mask[3]) |=> rd_data[31:24] == 8'h00)
      else $error("Top byte lane not masked.");

   // Captured data appears only after a feedback edge, two stages late.
   AST_FB_SAMPLE: assert property (@(posedge clk) disable iff (!rstn)
      rd_valid |-> ($past(fb_s1, 2) && !$past(fb_s2, 2)))
      else $error("Read sampled without a feedback edge.");

endmodule

// file: src/sdram_pin_pkg.sv
// Shared constants, command codes and signal bundles for the synchronous memory pin interface.
package sdram_pin_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W  = 32;  // Memory data bus width.
   localparam int LANES   = 4;   // Byte lanes, one data mask bit each.
   localparam int CHIPS   = 4;   // Chip selects.
   localparam int CLKS    = 2;   // Memory clock outputs.
   localparam int LANE_W  = 8;   // Bits per byte lane.

   // ----------------------------------------------------------------
   // Values shown on the pins during and just after reset, and the reset value of the clock run flags
   // ----------------------------------------------------------------
   localparam logic [CLKS-1:0]  RST_MEM_CLK   = 2'h3;  // Both memory clocks high.
   localparam logic             RST_CKE       = 1'h1;  // Clock enable high.
   localparam logic [CHIPS-1:0] RST_CHIP_SEL  = 4'hf;  // All chip selects high.
   localparam logic [2:0]       RST_STROBES   = 3'h7;  // Row, column and write strobes high.
   localparam logic [LANES-1:0] RST_DMASK     = 4'hf;  // All data masks high.
   localparam logic             RST_FLASH_RUN = 1'h0;  // Flash held in initialize/power-down.
   localparam logic [1:0]       RST_CLK_EN    = 2'h0;  // Clock run flags cleared in reset.

   // ----------------------------------------------------------------
   // Memory command set and its strobe codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_DESELECT  = 4'h0,
      CMD_NOP       = 4'h1,
      CMD_ACTIVATE  = 4'h2,
      CMD_READ      = 4'h3,
      CMD_WRITE     = 4'h4,
      CMD_PRECHARGE = 4'h5,
      CMD_REFRESH   = 4'h6,
      CMD_LOAD_MODE = 4'h7,
      CMD_BURST_END = 4'h8
   } mem_cmd_e;

   // Strobe codes, ordered row, column, write enable; all active low.
   localparam logic [2:0] STB_NOP       = 3'h7;
   localparam logic [2:0] STB_ACTIVATE  = 3'h3;
   localparam logic [2:0] STB_READ      = 3'h5;
   localparam logic [2:0] STB_WRITE     = 3'h4;
   localparam logic [2:0] STB_PRECHARGE = 3'h2;
   localparam logic [2:0] STB_REFRESH   = 3'h1;
   localparam logic [2:0] STB_LOAD_MODE = 3'h0;
   localparam logic [2:0] STB_BURST_END = 3'h6;

   // ----------------------------------------------------------------
   // Bundles
   // ----------------------------------------------------------------
   typedef struct packed {
      mem_cmd_e         cmd;        // Command to issue.
      logic [1:0]       chip;       // Index of the chip select to assert.
      logic [LANES-1:0] byte_mask;  // High blocks a lane.
      logic             cke;        // Requested clock enable level.
   } mem_req_s;

   typedef struct packed {
      logic [CHIPS-1:0] chip_sel_n;  // Chip selects, active low.
      logic             row_n;       // Row strobe, active low.
      logic             col_n;       // Column strobe, active low.
      logic             we_n;        // Write enable, active low.
   } mem_pins_s;

endpackage

// file: tb/sdram_mem_model.sv
// Behavioural external synchronous memory that answers each read with a fixed word.
`timescale 1ns/1ps

module sdram_mem_model #(
   parameter logic [31:0] READ_WORD = 32'ha1b2_c3d4  // Word returned by every read.
) (
   input  wire logic                                 clk,
   input  wire logic [sdram_pin_pkg::CHIPS-1:0]      mem_chip_sel_n,
   input  wire logic                                 mem_row_strobe_n,
   input  wire logic                                 mem_col_strobe_n,
   input  wire logic                                 mem_write_en_n,
   input  wire logic [sdram_pin_pkg::LANES-1:0]      mem_data_mask,
   output logic                                      mem_feedback_clk_in,
   output logic      [sdram_pin_pkg::DATA_W-1:0]     mem_dq_in
);
   import sdram_pin_pkg::*;

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   logic rd_cmd;  // A selected chip sees a read on the strobes.
   assign rd_cmd = (mem_chip_sel_n != 4'hf) && ({mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} == STB_READ);

   initial begin
      mem_feedback_clk_in = 1'b0;
      mem_dq_in = 32'h0;
   end

   // Returns one feedback pulse with the word; lanes with their mask high keep
   // their buffers off, so those lanes toggle and never show a stable value.
   always @(posedge clk) begin
      mem_feedback_clk_in <= rd_cmd;
      for (int i = 0; i < LANES; i++) begin
         if (rd_cmd && !mem_data_mask[i]) begin
            mem_dq_in[i*8 +: 8] <= READ_WORD[i*8 +: 8];
         end else begin
            mem_dq_in[i*8 +: 8] <= ~mem_dq_in[i*8 +: 8];
         end
      end
   end
endmodule

// file: tb/testbench.sv
// Self-checking testbench for the synchronous memory pin interface.
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("MISMATCH t=%0t %s", $time, msg); end end

module testbench;
   import sdram_pin_pkg::*;

   localparam logic [31:0] WORD = 32'ha1b2_c3d4;  // Word the memory model returns.
   logic clk, rstn, req_valid, flash_run, mem_feedback_clk_in, rd_valid;
   logic mem_cke, mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n, flash_init_powerdown_n;
   logic [CLKS-1:0]   mem_clk_out_en, mem_clk_out;
   logic [CHIPS-1:0]  mem_chip_sel_n;
   logic [LANES-1:0]  mem_data_mask;
   logic [DATA_W-1:0] mem_dq_in, rd_data;
   mem_req_s          req;
   int                n_fail, check_count;

   sdram_pin_interface u_sdram_pin_interface (.clk, .rstn, .mem_clk_out_en, .req_valid, .req, .flash_run,
      .mem_feedback_clk_in, .mem_dq_in, .mem_clk_out, .mem_cke, .mem_chip_sel_n, .mem_row_strobe_n,
      .mem_col_strobe_n, .mem_write_en_n, .mem_data_mask, .flash_init_powerdown_n, .rd_data, .rd_valid);
   sdram_mem_model #(.READ_WORD(WORD)) u_sdram_mem_model (.clk, .mem_chip_sel_n, .mem_row_strobe_n,
      .mem_col_strobe_n, .mem_write_en_n, .mem_data_mask, .mem_feedback_clk_in, .mem_dq_in);

   // System clock, 4 ns period.
   always #2 clk = ~clk;

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Sends one command for one cycle and lands just after the edge that shows it.
   task automatic issue(mem_cmd_e c, logic [1:0] ch, logic [3:0] m, logic k);
      @(posedge clk) req_valid <= 1'b1;
      req <= '{cmd: c, chip: ch, byte_mask: m, cke: k};
      @(posedge clk) req_valid <= 1'b0;
      #1;
   endtask

   // Holds reset for two cycles and checks every pin level inside it, and every pin but the flash pin just after release.
   task automatic do_reset();
      @(posedge clk) rstn <= 1'b0;
      @(posedge clk);
      #1;
      `CHECK({mem_chip_sel_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n}, 7'h7f, "strobes")
      `CHECK({mem_cke, mem_data_mask}, 5'h1f, "cke or masks")
      `CHECK(flash_init_powerdown_n, 1'b0, "flash pin")
      `CHECK(mem_clk_out, 2'h3, "clocks high phase")
      #2 `CHECK(mem_clk_out, 2'h3, "clocks low phase")
      @(posedge clk) rstn <= 1'b1;
      #1 `CHECK(mem_clk_out, 2'h3, "clocks high after release")
      #2 `CHECK(mem_clk_out, 2'h3, "clocks low after release")
      @(posedge clk) #1;
      `CHECK({mem_chip_sel_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n}, 7'h7f, "idle strobes")
      `CHECK({mem_cke, mem_data_mask}, 5'h1f, "idle cke or masks")
   endtask

   // Every enable pattern: an enabled clock follows clk, a disabled one stays low.
   task automatic test_clocks();
      for (int e = 0; e < 4; e++) begin
         @(posedge clk) mem_clk_out_en <= e[1:0];
         repeat (2) @(posedge clk);
         #1 `CHECK(mem_clk_out, e[1:0], "clock high phase")
         #2 `CHECK(mem_clk_out, 2'h0, "clock low phase")
      end
   endtask

   // The flash pin follows the run request once out of reset.
   task automatic test_flash();
      for (int v = 1; v >= 0; v--) begin
         @(posedge clk) flash_run <= v[0];
         @(posedge clk) #1 `CHECK(flash_init_powerdown_n, v[0], "flash follow")
      end
   endtask

   // Every command code, its strobes, select, masks and clock enable.
   task automatic test_commands();
      mem_cmd_e   cmds [9] = '{CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
                               CMD_REFRESH, CMD_LOAD_MODE, CMD_BURST_END};
      logic [2:0] stb [9] = '{3'h7, 3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
      logic [3:0] sel;
      for (int i = 0; i < 9; i++) begin
         issue(cmds[i], i[1:0], 4'h2, i[0]);
         sel = (cmds[i] == CMD_DESELECT) ? 4'hf : ~(4'h1 << i[1:0]);
         `CHECK({mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n}, stb[i], "strobes")
         `CHECK(mem_chip_sel_n, sel, "select")
         `CHECK(mem_data_mask, (cmds[i] inside {CMD_READ, CMD_WRITE}) ? 4'h2 : 4'hf, "mask")
         `CHECK(mem_cke, i[0], "cke")
         @(posedge clk) #1 `CHECK({mem_row_strobe_n, mem_data_mask}, 5'h1f, "idle")
      end
      repeat (8) @(posedge clk);
   endtask

   // A read per mask pattern; data comes only on the feedback pulse, masked lanes zero.
   task automatic test_read(logic [3:0] m);
      logic [31:0] exp;
      int          n;
      for (int i = 0; i < 4; i++) exp[i*8 +: 8] = m[i] ? 8'h0 : WORD[i*8 +: 8];
      repeat (3) @(posedge clk) #1 `CHECK(rd_valid, 1'b0, "no feedback, no capture")
      issue(CMD_READ, 2'h2, m, 1'b1);
      `CHECK(mem_data_mask, m, "read mask")
      n = 0;
      while (rd_valid !== 1'b1 && n < 10) begin
         @(posedge clk) #1 n++;
      end
      if (n == 10) begin
         n_fail++;
         $display("MISMATCH t=%0t no read answer", $time);
         complete_run();
      end else begin
         `CHECK(rd_data, exp, "read word")
         @(posedge clk) #1 `CHECK(rd_valid, 1'b0, "single pulse")
      end
   endtask

   // Main sequence; a second reset comes with cke low, flash running and clocks off.
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      req_valid = 1'b0;
      req = '{cmd: CMD_NOP, chip: 2'h0, byte_mask: 4'hf, cke: 1'b1};
      flash_run = 1'b0;
      mem_clk_out_en = 2'h0;
      n_fail = 0;
      check_count = 0;
      do_reset();
      test_clocks();
      test_flash();
      test_commands();
      test_read(4'h0);
      test_read(4'h5);
      test_read(4'ha);
      test_read(4'hf);
      issue(CMD_NOP, 2'h0, 4'hf, 1'b0);
      @(posedge clk) flash_run <= 1'b1;
      mem_clk_out_en <= 2'h0;
      do_reset();
      complete_run();
   end
endmodule
